// *** rtl/period_match_timer.sv ***
// What this block does
// - 8-bit count register, RW, reset to zero
// - Count source is oscillator divided by four
// - Prescale select: 00 by 1, 01 by 4, 1x by 16
// - Count up to period value, then wrap to zero
// - 8-bit period register, RW, reset to FFh
// - Matches drive 4-bit postscaler setting match flag
// - Postscale ratio is field value plus one
// - Count or control write clears both scalers
// - Control write keeps count value unchanged
// - Match pulse before postscaler feeds serial port
// - Control bit 7 reads zero; reset clears all but period (FFh)
`include "period_match_timer_defines.svh"

module period_match_timer
   import period_match_timer_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             serial_port_shift_tick,
   output logic             irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [1:0]  instr_div_q,  instr_div_d;
   logic [3:0]  prescale_q,   prescale_d;
   logic [7:0]  count_q,      count_d;
   logic [7:0]  period_q,     period_d;
   timer_ctrl_t ctrl_q,       ctrl_d;
   logic [3:0]  postscale_q,  postscale_d;
   logic        flag_q,       flag_d;
   logic        mask_q,       mask_d;
   logic        match_q,      match_d;
   logic [31:0] prdata_q,     prdata_d;
   logic        pslverr_q,    pslverr_d;

   logic        setup_phase;
   logic        access_wr;
   logic        wr_count;
   logic        wr_ctrl;
   logic        wr_period;
   logic        wr_flags;
   logic        wr_mask;
   logic        addr_hit;
   logic        instr_tick;
   logic        pre_tick;
   logic        period_match;
   logic        post_done;
   logic [3:0]  pre_last;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Zero wait states; read data is sampled in the setup cycle
   assign pready      = psel & penable;
   assign setup_phase = psel & ~penable;
   assign access_wr   = psel & penable & pwrite & pstrb[0];
   assign wr_count    = access_wr && paddr == `PMT_ADDR_COUNT;
   assign wr_ctrl     = access_wr && paddr == `PMT_ADDR_CONTROL;
   assign wr_period   = access_wr && paddr == `PMT_ADDR_PERIOD;
   assign wr_flags    = access_wr && paddr == `PMT_ADDR_FLAGS;
   assign wr_mask     = access_wr && paddr == `PMT_ADDR_MASK;
   assign addr_hit    = paddr == `PMT_ADDR_COUNT  || paddr == `PMT_ADDR_CONTROL ||
                        paddr == `PMT_ADDR_PERIOD || paddr == `PMT_ADDR_FLAGS ||
                        paddr == `PMT_ADDR_MASK;

   always_comb begin
      prdata_d  = prdata_q;
      pslverr_d = pslverr_q;
      if (setup_phase) begin
         pslverr_d = ~addr_hit;
         prdata_d  = 32'h0000_0000;
         unique case (paddr)
            `PMT_ADDR_COUNT:   prdata_d[7:0] = count_q;
            `PMT_ADDR_CONTROL: prdata_d[6:0] = ctrl_q;
            `PMT_ADDR_PERIOD:  prdata_d[7:0] = period_q;
            `PMT_ADDR_FLAGS:   prdata_d[`PMT_FLAG_BIT] = flag_q;
            `PMT_ADDR_MASK:    prdata_d[`PMT_FLAG_BIT] = mask_q;
            default:           prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata  = prdata_q;
   assign pslverr = pslverr_q & pready;

   // ----------------------------------------------------------------
   // Clock chain
   // ----------------------------------------------------------------
   // instruction rate enable
   assign instr_tick = instr_div_q == `PMT_INSTR_LAST;

   always_comb begin
      unique case (prescale_code_t'(ctrl_q.input_prescale_select))
         PRESCALE_1:   pre_last = `PMT_PRE_LAST_1;
         PRESCALE_4:   pre_last = `PMT_PRE_LAST_4;
         PRESCALE_16A,
         PRESCALE_16B: pre_last = `PMT_PRE_LAST_16;
      endcase
   end

   // Ticks are dropped in a control write cycle so the count holds
   assign pre_tick     = instr_tick && ctrl_q.period_timer_on && !wr_ctrl &&
                         !wr_count && prescale_q == pre_last;
   assign period_match = pre_tick && count_q == period_q;
   assign post_done    = postscale_q == ctrl_q.output_postscale_select;

   always_comb begin
      instr_div_d = instr_div_q + 2'h1;
      prescale_d  = prescale_q;
      count_d     = count_q;
      postscale_d = postscale_q;
      flag_d      = flag_q;
      match_d     = period_match;
      if (instr_tick && ctrl_q.period_timer_on) begin
         prescale_d = (prescale_q == pre_last) ? 4'h0 : prescale_q + 4'h1;
      end
      if (pre_tick) begin
         count_d = period_match ? `PMT_RST_COUNT : count_q + 8'h01;
      end
      if (period_match) begin
         postscale_d = post_done ? 4'h0 : postscale_q + 4'h1;
      end
      if (wr_flags && pwdata[`PMT_FLAG_BIT]) begin
         flag_d = 1'b0;
      end
      if (period_match && post_done) begin
         flag_d = 1'b1;
      end
      if (wr_count || wr_ctrl) begin
         prescale_d  = 4'h0;
         postscale_d = 4'h0;
      end
      if (wr_count) begin
         count_d = pwdata[7:0];
      end
   end

   always_comb begin
      ctrl_d   = ctrl_q;
      period_d = period_q;
      mask_d   = mask_q;
      if (wr_ctrl) begin
         ctrl_d = pwdata[6:0];
      end
      if (wr_period) begin
         period_d = pwdata[7:0];
      end
      if (wr_mask) begin
         mask_d = pwdata[`PMT_FLAG_BIT];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         instr_div_q <= 2'h0;
         prescale_q  <= 4'h0;
         count_q     <= `PMT_RST_COUNT;
         period_q    <= `PMT_RST_PERIOD;
         ctrl_q      <= `PMT_RST_CONTROL;
         postscale_q <= 4'h0;
         flag_q      <= 1'b0;
         mask_q      <= 1'b0;
         match_q     <= 1'b0;
      end else begin
         instr_div_q <= instr_div_d;
         prescale_q  <= prescale_d;
         count_q     <= count_d;
         period_q    <= period_d;
         ctrl_q      <= ctrl_d;
         postscale_q <= postscale_d;
         flag_q      <= flag_d;
         mask_q      <= mask_d;
         match_q     <= match_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // match before postscaler
   assign serial_port_shift_tick = match_q;
   assign irq                    = flag_q & mask_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   instr_quarter_a: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
      else $error("instruction tick not every fourth clock");

   prescale_bound_a: assert property (!$past(wr_ctrl) |-> prescale_q <= pre_last)
      else $error("prescaler beyond selected ratio");

   count_wrap_a: assert property (period_match |=> count_q == 8'h00)
      else $error("count did not wrap after match");

   count_step_a: assert property (pre_tick && !period_match |=>
                                  count_q == $past(count_q) + 8'h01)
      else $error("count did not step by one");

   timer_halt_a: assert property (!ctrl_q.period_timer_on && !wr_count |=>
                                  $stable(count_q))
      else $error("count moved while timer off");

   scaler_clear_a: assert property ((wr_count || wr_ctrl) |=>
                                    prescale_q == 4'h0 && postscale_q == 4'h0)
      else $error("scalers not cleared by write");

   ctrl_keep_a: assert property (wr_ctrl |=> count_q == $past(count_q))
      else $error("control write changed count");

   flag_set_a: assert property (period_match && post_done |=> flag_q)
      else $error("flag not set at postscaled match");

   flag_sticky_a: assert property (flag_q && !(wr_flags && pwdata[`PMT_FLAG_BIT])
                                   |=> flag_q)
      else $error("flag dropped without software clear");

   shift_tick_a: assert property (period_match |=> serial_port_shift_tick)
      else $error("match pulse not passed to serial port");

   ctrl_read_a: assert property (setup_phase && paddr == `PMT_ADDR_CONTROL
                                 |=> prdata[31:7] == 25'h0)
      else $error("control upper bits not zero");

   count_write_a: assert property (wr_count |=> count_q == $past(pwdata[7:0]))
      else $error("count write not taken");

   count_read_a: assert property (setup_phase && paddr == `PMT_ADDR_COUNT
                                  |=> prdata == {24'h00_0000, $past(count_q)})
      else $error("count read data wrong");

   period_write_a: assert property (wr_period |=> period_q == $past(pwdata[7:0]))
      else $error("period write not taken");

   halt_prescale_a: assert property (!ctrl_q.period_timer_on |=>
                                     $stable(prescale_q) || prescale_q == 4'h0)
      else $error("prescaler moved while timer off");

   post_hold_a: assert property (!period_match |=>
                                 $stable(postscale_q) || postscale_q == 4'h0)
      else $error("postscaler moved without match");

   flag_quiet_a: assert property (!flag_q && !(period_match && post_done) |=> !flag_q)
      else $error("flag set without postscaled match");

   flag_clear_a: assert property (wr_flags && pwdata[`PMT_FLAG_BIT] &&
                                  !(period_match && post_done) |=> !flag_q)
      else $error("flag not cleared by software");

   tick_only_a: assert property (!period_match |=> !serial_port_shift_tick)
      else $error("serial port pulse without match");

   unmapped_err_a: assert property (pready && !addr_hit |-> pslverr)
      else $error("unmapped access without error");

   wrap_seen_c:     cover property (period_match ##1 count_q == 8'h00);
   post16_seen_c:   cover property (period_match && post_done &&
                                    ctrl_q.output_postscale_select == 4'hF);
   clear_race_c:    cover property (wr_flags && period_match && post_done);
   unmapped_read_c: cover property (pready && pslverr);
   strobe_off_c:    cover property (psel && penable && pwrite && !pstrb[0]);

endmodule

// *** rtl/period_match_timer_defines.svh ***
`ifndef PERIOD_MATCH_TIMER_DEFINES_SVH
`define PERIOD_MATCH_TIMER_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PMT_IDX_COUNT      10'h011
`define PMT_IDX_CONTROL    10'h012
`define PMT_IDX_PERIOD     10'h092
`define PMT_IDX_FLAGS      10'h00C
`define PMT_IDX_MASK       10'h08C
`define PMT_ADDR_COUNT     {`PMT_IDX_COUNT, 2'b00}
`define PMT_ADDR_CONTROL   {`PMT_IDX_CONTROL, 2'b00}
`define PMT_ADDR_PERIOD    {`PMT_IDX_PERIOD, 2'b00}
`define PMT_ADDR_FLAGS     {`PMT_IDX_FLAGS, 2'b00}
`define PMT_ADDR_MASK      {`PMT_IDX_MASK, 2'b00}

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define PMT_RST_COUNT      8'h00
`define PMT_RST_PERIOD     8'hFF
`define PMT_RST_CONTROL    7'h00
`define PMT_FLAG_BIT       1

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define PMT_OSC_PER_INSTR  3'h4
`define PMT_INSTR_LAST     2'(`PMT_OSC_PER_INSTR - 3'h1)
`define PMT_PRE_LAST_1     4'h0
`define PMT_PRE_LAST_4     4'h3
`define PMT_PRE_LAST_16    4'hF

`endif

// *** rtl/period_match_timer_pkg.sv ***
package period_match_timer_pkg;

   // Implemented control bits; bit 7 is not stored
   typedef struct packed {
      logic [3:0] output_postscale_select;
      logic       period_timer_on;
      logic [1:0] input_prescale_select;
   } timer_ctrl_t;

   typedef enum logic [1:0] {
      PRESCALE_1,
      PRESCALE_4,
      PRESCALE_16A,
      PRESCALE_16B
   } prescale_code_t;

endpackage

// *** test/test_period_match_timer.sv ***
`include "period_match_timer_defines.svh"

module test_period_match_timer;
   timeunit 1ns;
   timeprecision 100ps;
   import period_match_timer_pkg::*;

   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        serial_port_shift_tick;
   logic        irq;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          c;
   int          n;
   logic [31:0] q;
   logic        e;
   // Postscale codes: both ends and one inside
   logic [3:0]  c_codes[3] = '{4'h0, 4'h1, 4'hF};

   period_match_timer DUT (
      .mclk                   (mclk),
      .rst                    (rst),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .pstrb                  (pstrb),
      .pready                 (pready),
      .prdata                 (prdata),
      .pslverr                (pslverr),
      .serial_port_shift_tick (serial_port_shift_tick),
      .irq                    (irq)
   );

   always #2.5 mclk = ~mclk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic timeout(input string what);
      $display("unexpected timeout waiting for %s", what);
      n_mismatch++;
      wrap_up();
   endtask

   task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         $display("unexpected %s expected %h seen %h", what, x, g);
         n_mismatch++;
      end
   endtask

   task automatic step;
      @(posedge mclk);
      #1;
   endtask

   // Request held until the edge where pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) timeout("pready");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
      apb(1'b0, a, 32'h0);
      chk(what, x, q);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask

   function automatic logic [31:0] ctl(logic [3:0] post, logic on, logic [1:0] pre);
      timer_ctrl_t t;
      t = '{post, on, pre};
      return {25'h0, t};
   endfunction

   // Cycles until the next shift tick, at least one
   task automatic gap(output int cnt);
      cnt = 0;
      do begin
         step();
         cnt++;
      end while (serial_port_shift_tick !== 1'b1 && cnt < 500);
      if (cnt >= 500) timeout("shift tick");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      // Reset values
      rd("count", `PMT_ADDR_COUNT, 32'h0, 1'b0);
      rd("control", `PMT_ADDR_CONTROL, 32'h0, 1'b0);
      rd("period", `PMT_ADDR_PERIOD, 32'hFF, 1'b0);
      rd("flags", `PMT_ADDR_FLAGS, 32'h0, 1'b0);
      rd("unmapped", 12'h004, 32'h0, 1'b1);
      wr(`PMT_ADDR_CONTROL, 32'hFF);
      rd("control bit7", `PMT_ADDR_CONTROL, 32'h7F, 1'b0);
      wr(`PMT_ADDR_CONTROL, 32'h0);
      // Count kept across control write, halted while off
      wr(`PMT_ADDR_COUNT, 32'h05);
      wr(`PMT_ADDR_CONTROL, 32'h0);
      rd("count after control", `PMT_ADDR_COUNT, 32'h05, 1'b0);
      // Byte lane 0 off: write ignored
      pstrb <= 4'h0;
      wr(`PMT_ADDR_COUNT, 32'h33);
      pstrb <= 4'hF;
      rd("count strobe off", `PMT_ADDR_COUNT, 32'h05, 1'b0);
      wr(`PMT_ADDR_CONTROL, ctl(4'h0, 1'b1, 2'd0));
      repeat (40) step();
      wr(`PMT_ADDR_CONTROL, 32'h0);
      apb(1'b0, `PMT_ADDR_COUNT, 32'h0);
      chk("count moved", 32'h1, {31'h0, q !== 32'h05});
      repeat (40) step();
      rd("count halted", `PMT_ADDR_COUNT, q, 1'b0);
      // Match interval per prescale code; zero count avoids a long run to FFh
      wr(`PMT_ADDR_PERIOD, 32'h02);
      wr(`PMT_ADDR_COUNT, 32'h0);
      for (int p = 0; p < 4; p++) begin
         wr(`PMT_ADDR_CONTROL, ctl(4'h0, 1'b1, p[1:0]));
         gap(c);
         gap(c);
         chk("tick interval", 12 * (p == 0 ? 1 : (p == 1 ? 4 : 16)), c);
      end
      // Scaler clear: first match 16 ticks later, tick phase varies by 3
      wr(`PMT_ADDR_PERIOD, 32'h00);
      for (int k = 0; k < 2; k++) begin
         gap(c);
         repeat (20) step();
         if (k == 0)
            wr(`PMT_ADDR_COUNT, 32'h0);
         else
            wr(`PMT_ADDR_CONTROL, ctl(4'h0, 1'b1, 2'd2));
         gap(c);
         chk("first tick delay", 32'h1, {31'h0, c >= 61 && c <= 64});
      end
      // Matches per flag
      wr(`PMT_ADDR_PERIOD, 32'h02);
      wr(`PMT_ADDR_MASK, 32'h02);
      foreach (c_codes[i]) begin
         wr(`PMT_ADDR_CONTROL, 32'h0);
         wr(`PMT_ADDR_COUNT, 32'h0);
         wr(`PMT_ADDR_FLAGS, 32'h02);
         rd("flags cleared", `PMT_ADDR_FLAGS, 32'h0, 1'b0);
         wr(`PMT_ADDR_CONTROL, ctl(c_codes[i], 1'b1, 2'd0));
         n = 0;
         c = 0;
         while (irq !== 1'b1 && c < 400) begin
            step();
            c++;
            if (serial_port_shift_tick === 1'b1) n++;
         end
         if (c >= 400) timeout("irq");
         repeat (2) begin
            step();
            if (serial_port_shift_tick === 1'b1) n++;
         end
         chk("matches per flag", c_codes[i] + 1, n);
      end
      // Sticky flag, mask and clear
      repeat (30) step();
      rd("flag sticky", `PMT_ADDR_FLAGS, 32'h02, 1'b0);
      wr(`PMT_ADDR_MASK, 32'h0);
      step();
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`PMT_ADDR_CONTROL, 32'h0);
      wr(`PMT_ADDR_MASK, 32'h02);
      step();
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(`PMT_ADDR_FLAGS, 32'h02);
      rd("flag cleared", `PMT_ADDR_FLAGS, 32'h0, 1'b0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // Second reset while the timer runs
      wr(`PMT_ADDR_PERIOD, 32'h07);
      wr(`PMT_ADDR_CONTROL, ctl(4'h3, 1'b1, 2'd1));
      repeat (50) step();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd("count after reset", `PMT_ADDR_COUNT, 32'h0, 1'b0);
      rd("period after reset", `PMT_ADDR_PERIOD, 32'hFF, 1'b0);
      rd("control after reset", `PMT_ADDR_CONTROL, 32'h0, 1'b0);
      rd("flags after reset", `PMT_ADDR_FLAGS, 32'h0, 1'b0);
      wrap_up();
   end
endmodule
